// ---- src/srmp_pkg.sv ----
/*
 * Constants for the serial register map port: frame layout, map size,
 * sequencer states and reset values of the register map.
 * Assumes nothing of its surroundings; pure definitions.
 */
package srmp_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int DATA_W = 16;
    localparam int ADDR_W = 5;
    localparam int DEV_W = 2;
    localparam int MAP_DEPTH = 32;
    localparam int HDR_BITS = 8;
    localparam int FRAME_BITS = 24;
    localparam logic [1:0] DEV_ADDR = 2'h1;
    localparam logic DIR_WRITE = 1'h0;
    localparam logic DIR_READ = 1'h1;
    localparam logic [4:0] RESET_LOC = 5'h00;

    // ------------------------------------------------------------
    // Frame sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SRMP_IDLE = 2'b00,
        SRMP_HDR = 2'b01,
        SRMP_DATA = 2'b10,
        SRMP_SKIP = 2'b11
    } srmp_state_e;

    // ------------------------------------------------------------
    // Map reset value (same for every location; values are arbitrary)
    // ------------------------------------------------------------
    localparam logic [15:0] MAP_RESET = 16'h0000;

endpackage : srmp_pkg

// ---- src/srmp_sync.sv ----
/*
 * Two-flop synchroniser for one level coming from outside the clock
 * domain. Assumes clk is the block clock and rst_n asynchronous.
 */
`timescale 1ns/1ps
module srmp_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    // Reset to the pin's idle level, so no false edge follows reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1 <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule : srmp_sync

// ---- src/srmp_port.sv ----
/*
 * Device-side serial configuration port with a 32 x 16 register map.
 * Assumes: select, shift clock, data line and hardware reset pin arrive
 * from outside the clk domain; shift clock is far slower than clk.
 */
`timescale 1ns/1ps
module srmp_port #(
    parameter int DEPTH = srmp_pkg::MAP_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device pins
    input wire logic hard_reset_pin,
    input wire logic sel_n,
    input wire logic shift_clk,
    input wire logic serial_io_line_in,
    output logic serial_io_line_out,
    output logic serial_io_line_oe,
    // Map contents for the rest of the device
    output logic [DEPTH*16-1:0] map_flat
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic sel_s;
    logic sck_s;
    logic sdi_s;
    logic hrst_s;
    logic sel_d;
    logic sck_d;

    // Select idles high; a low reset level would fake a frame start
    srmp_sync #(
        .RESET_VAL(1'b1)
    ) u_sel (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(sel_n),
        .sync_out(sel_s)
    );
    // Return-to-zero shift clock idles low
    srmp_sync #(
        .RESET_VAL(1'b0)
    ) u_sck (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(shift_clk),
        .sync_out(sck_s)
    );
    srmp_sync #(
        .RESET_VAL(1'b0)
    ) u_sdi (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(serial_io_line_in),
        .sync_out(sdi_s)
    );
    srmp_sync #(
        .RESET_VAL(1'b0)
    ) u_hrst (
        .clk(clk),
        .rst_n(rst_n),
        .async_in(hard_reset_pin),
        .sync_out(hrst_s)
    );

    // ------------------------------------------------------------
    // Edge and event decode
    // ------------------------------------------------------------
    srmp_pkg::srmp_state_e state;
    srmp_pkg::srmp_state_e next_state;
    logic [4:0] bit_cnt;
    logic [7:0] hdr;
    logic [15:0] shreg;
    logic [15:0] map_q [DEPTH];
    logic out_bit;
    logic out_en;

    wire sel_active = ~sel_s & ~hrst_s;
    wire sck_rise = sck_s & ~sck_d;
    wire sck_fall = ~sck_s & sck_d;
    wire sel_rise = sel_s & ~sel_d;
    wire [7:0] hdr_next = {hdr[6:0], sdi_s};
    wire hdr_done = (bit_cnt == 5'(srmp_pkg::HDR_BITS - 1));
    wire is_read = hdr[7] == srmp_pkg::DIR_READ;
    wire [1:0] hdr_dev = hdr[6:5];
    wire [4:0] hdr_loc = hdr[4:0];
    wire dev_hit_next = hdr_next[6:5] == srmp_pkg::DEV_ADDR;
    // frame ends after 24 bits; later bits are dropped
    wire frame_full = (bit_cnt == 5'(srmp_pkg::FRAME_BITS));
    wire wipe_loc = (hdr_loc == srmp_pkg::RESET_LOC);
    // access to location zero wipes the map
    wire map_wipe = sel_rise & (state == srmp_pkg::SRMP_DATA) & wipe_loc;
    // write commits only a full word
    wire map_write = sel_rise & (state == srmp_pkg::SRMP_DATA) & ~is_read
                     & ~wipe_loc & frame_full;
    wire [4:0] data_idx = 5'(srmp_pkg::FRAME_BITS - 1) - bit_cnt;
    wire [15:0] rd_word = map_q[hdr_loc];

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            srmp_pkg::SRMP_IDLE: begin
                if (sel_active) begin
                    next_state = srmp_pkg::SRMP_HDR;
                end
            end
            srmp_pkg::SRMP_HDR: begin
                if (!sel_active) begin
                    next_state = srmp_pkg::SRMP_IDLE;
                end else if (sck_rise && hdr_done) begin
                    next_state = dev_hit_next ? srmp_pkg::SRMP_DATA
                                              : srmp_pkg::SRMP_SKIP;
                end
            end
            srmp_pkg::SRMP_DATA: begin
                if (!sel_active) begin
                    next_state = srmp_pkg::SRMP_IDLE;
                end
            end
            srmp_pkg::SRMP_SKIP: begin
                if (!sel_active) begin
                    next_state = srmp_pkg::SRMP_IDLE;
                end
            end
            default: begin
                next_state = srmp_pkg::SRMP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= srmp_pkg::SRMP_IDLE;
            sel_d <= 1'b1;
            sck_d <= 1'b0;
        end else begin
            state <= next_state;
            sel_d <= sel_s;
            sck_d <= sck_s;
        end
    end

    // ------------------------------------------------------------
    // Shift path
    // ------------------------------------------------------------
    // shift only on rising edges while selected
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt <= 5'h00;
            hdr <= 8'h00;
            shreg <= 16'h0000;
        end else if (!sel_active) begin
            bit_cnt <= 5'h00;
        end else if (sck_rise && state != srmp_pkg::SRMP_IDLE
                     && !frame_full) begin
            bit_cnt <= bit_cnt + 5'h01;
            if (state == srmp_pkg::SRMP_HDR) begin
                hdr <= hdr_next;
            end else begin
                shreg <= {shreg[14:0], sdi_s};
            end
        end
    end

    // ------------------------------------------------------------
    // Read driver
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_en <= 1'b0;
            out_bit <= 1'b0;
        end else if (!sel_active || !is_read || hdr_dev != srmp_pkg::DEV_ADDR
                     || state != srmp_pkg::SRMP_DATA) begin
            // released after read or when not addressed
            out_en <= 1'b0;
        end else if (sck_fall) begin
            out_en <= 1'b0;
        end else if (sck_rise && !frame_full) begin
            // drive next bit on rising edge
            out_en <= 1'b1;
            out_bit <= rd_word[4'(data_idx)];
        end
    end
    assign serial_io_line_out = out_bit;
    assign serial_io_line_oe = out_en;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    // one word per location, read and write except location zero, whose access wipes the map
    for (genvar i = 0; i < DEPTH; i++) begin : g_map
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                map_q[i] <= srmp_pkg::MAP_RESET;
            end else if (hrst_s || map_wipe) begin
                // whole map back to reset values
                map_q[i] <= srmp_pkg::MAP_RESET;
            end else if (map_write && hdr_loc == 5'(i)) begin
                map_q[i] <= shreg;
            end
        end
        assign map_flat[i*16 +: 16] = map_q[i];
    end

endmodule : srmp_port

// ---- dv/srmp_port_monitor.sv ----
/* Checker for srmp_port, bound to every instance.
   Sees only the port pins; clk is the block clock. */
`timescale 1ns/1ps
module srmp_port_monitor #(
    parameter int DEPTH = srmp_pkg::MAP_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Device pins and map
    input wire logic hard_reset_pin,
    input wire logic sel_n,
    input wire logic shift_clk,
    input wire logic serial_io_line_in,
    input wire logic serial_io_line_out,
    input wire logic serial_io_line_oe,
    input wire logic [DEPTH*16-1:0] map_flat
);
    logic [3:0] sel_hi_cnt;
    logic [3:0] hr_lo_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ------------------------------------------------------------
    // Run lengths; saturate so long idle spans stay cheap
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_hi_cnt <= 4'h0;
            hr_lo_cnt <= 4'h0;
        end else begin
            sel_hi_cnt <= sel_n ? sel_hi_cnt + 4'(sel_hi_cnt != 4'hF)
                                : 4'h0;
            hr_lo_cnt <= hard_reset_pin ? 4'h0
                                        : hr_lo_cnt + 4'(hr_lo_cnt != 4'hF);
        end
    end
    chk_idle_no_drive: assert property (
        sel_hi_cnt > 4'h6 |-> !serial_io_line_oe)
        else $error("line driven while deselected");
    chk_map_commit_only: assert property (!$stable(map_flat) |->
        (sel_hi_cnt inside {[4'h1:4'h8]}) || hr_lo_cnt < 4'h6)
        else $error("map changed outside a commit");
    chk_pin_clears_map: assert property (hard_reset_pin [*5] |->
        map_flat == {DEPTH{srmp_pkg::MAP_RESET}})
        else $error("map not cleared");
    chk_pin_line_input: assert property (hard_reset_pin [*5] |->
        !serial_io_line_oe) else $error("line driven in reset");
    chk_fall_releases: assert property ($fell(shift_clk) |->
        ##[1:5] !serial_io_line_oe) else $error("line not released");
    chk_bit_holds: assert property (
        serial_io_line_oe && $past(serial_io_line_oe)
        |-> $stable(serial_io_line_out)) else $error("read bit moved");
    chk_drive_on_rise: assert property ($rose(serial_io_line_oe) |->
        shift_clk && $past(shift_clk, 2) && !sel_n)
        else $error("bad drive start");
    chk_drive_span: assert property ($rose(serial_io_line_oe) |->
        serial_io_line_oe [*3]) else $error("drive too short");
    cover property ($rose(serial_io_line_oe));
    cover property (hard_reset_pin [*5]);
    cover property (!$stable(map_flat) && sel_hi_cnt != 4'h0);
endmodule : srmp_port_monitor
bind srmp_port srmp_port_monitor #(.DEPTH(DEPTH)) u_srmp_port_monitor (
    .clk(clk), .rst_n(rst_n), .hard_reset_pin(hard_reset_pin),
    .sel_n(sel_n), .shift_clk(shift_clk),
    .serial_io_line_in(serial_io_line_in),
    .serial_io_line_out(serial_io_line_out),
    .serial_io_line_oe(serial_io_line_oe), .map_flat(map_flat));

// ---- dv/srmp_host.sv ----
/* Serial host model: select, return-to-zero shift clock, data line.
   Assumes clk is the bench clock; the bench starts each frame. */
`timescale 1ns/1ps
module srmp_host (
    // Bench clock
    input wire logic clk,
    // Pins towards the device
    output logic sel_n,
    output logic shift_clk,
    output wire logic line,
    input wire logic dev_out,
    input wire logic dev_oe
);
    logic drv = 1'b0;
    logic d = 1'b0;
    logic last = 1'b0;
    // one shared line
    // Released line toggles so a stale bit is never read back
    assign line = dev_oe ? dev_out : (drv ? d : ~last);
    always_ff @(posedge clk) last <= line;
    // select and shift clock stay static outside frames
    initial begin
        sel_n = 1'b1;
        shift_clk = 1'b0;
    end
    task automatic half(input logic level);
        repeat (4) @(posedge clk);
        #1 shift_clk = level;
    endtask : half
    task automatic xfer(input logic [23:0] frm, output logic [15:0] rd);
        rd = 16'h0000;
        @(posedge clk);
        #1 sel_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            drv = !(frm[23] && i < 16);
            d = frm[i];
            half(1'b1);
            half(1'b0);
            if (i < 16) rd[i] = line;
        end
        half(1'b0);
        sel_n = 1'b1;
        drv = 1'b0;
    endtask : xfer
endmodule : srmp_host

// ---- dv/tb.sv ----
/* Self-checking bench for srmp_port driven by the serial host model.
   Assumes a 40 MHz clock and a 200 ns shift clock. */
`timescale 1ns/1ps
module tb;
    logic clk, rst_n, hard_reset_pin, sel_n, shift_clk, line, dout, doe;
    int oe_rises = 0;
    logic doe_q = 1'b0;
    logic [16*srmp_pkg::MAP_DEPTH-1:0] map_flat;
    logic [15:0] exp_map [srmp_pkg::MAP_DEPTH];
    logic [15:0] rd;
    logic [31:0] rnd;
    int failures = 0;
    int cmp_count = 0;
    srmp_port #(.DEPTH(srmp_pkg::MAP_DEPTH)) u_srmp_port (
        .clk(clk), .rst_n(rst_n), .hard_reset_pin(hard_reset_pin),
        .sel_n(sel_n), .shift_clk(shift_clk), .serial_io_line_in(line),
        .serial_io_line_out(dout), .serial_io_line_oe(doe),
        .map_flat(map_flat));
    srmp_host u_srmp_host (.clk(clk), .sel_n(sel_n), .shift_clk(shift_clk),
        .line(line), .dev_out(dout), .dev_oe(doe));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Count drive bursts; a read drives once per data bit
    always @(posedge clk) begin
        doe_q <= doe;
        if (doe === 1'b1 && doe_q !== 1'b1)
            oe_rises <= oe_rises + 1;
    end
    function automatic logic [15:0] exp_rises(input logic hit, dir);
        return (hit && dir) ? 16'(srmp_pkg::DATA_W) : 16'h0000;
    endfunction : exp_rises
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr
    task automatic check(input string what, input logic [15:0] e, s);
        cmp_count++;
        if (s !== e) begin
            $display("BAD %s expected %h seen %h", what, e, s);
            failures++;
        end
    endtask : check
    task automatic check_map();
        for (int i = 0; i < srmp_pkg::MAP_DEPTH; i++)
            check("map word", exp_map[i], map_flat[16*i +: 16]);
    endtask : check_map
    task automatic acc(input logic dir, input logic [1:0] dev,
            input logic [4:0] loc, input logic [15:0] wd);
        logic [15:0] old;
        logic hit;
        int base;
        old = exp_map[loc];
        hit = (dev === srmp_pkg::DEV_ADDR);
        base = oe_rises;
        u_srmp_host.xfer({dir, dev, loc, wd}, rd);
        repeat (8) @(posedge clk);
        if (hit && loc === srmp_pkg::RESET_LOC)
            exp_map = '{default: srmp_pkg::MAP_RESET};
        else if (hit && dir === srmp_pkg::DIR_WRITE)
            exp_map[loc] = wd;
        if (hit && dir === srmp_pkg::DIR_READ)
            check("read word", old, rd);
        check("drove line", exp_rises(hit, dir), 16'(oe_rises - base));
        check_map();
    endtask : acc
    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : give_verdict
    // Whole run is near 15400 cycles; 80000 cycles means a hang
    initial begin
        #2000000;
        failures++;
        give_verdict();
    end
    initial begin
        rst_n = 1'b0;
        hard_reset_pin = 1'b0;
        rnd = 32'h000125C9;
        exp_map = '{default: srmp_pkg::MAP_RESET};
        repeat (6) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge clk);
        check_map();
        for (int i = 1; i < srmp_pkg::MAP_DEPTH; i++) begin
            rnd = lfsr(rnd);
            acc(srmp_pkg::DIR_WRITE, srmp_pkg::DEV_ADDR, 5'(i), rnd[15:0]);
        end
        for (int i = 31; i > 0; i--)
            acc(srmp_pkg::DIR_READ, srmp_pkg::DEV_ADDR, 5'(i), 16'h0000);
        acc(srmp_pkg::DIR_READ, srmp_pkg::DEV_ADDR, 5'h00, 16'h0000);
        for (int k = 0; k < 8; k++) begin
            rnd = lfsr(rnd);
            acc(rnd[20], 2'(k), rnd[25:21], rnd[15:0]);
        end
        acc(srmp_pkg::DIR_WRITE, srmp_pkg::DEV_ADDR, 5'h1F, 16'hA5C3);
        acc(srmp_pkg::DIR_WRITE, srmp_pkg::DEV_ADDR, 5'h00, 16'hFFFF);
        acc(srmp_pkg::DIR_WRITE, srmp_pkg::DEV_ADDR, 5'h10, 16'h8001);
        #1 hard_reset_pin = 1'b1;
        repeat (10) @(posedge clk);
        exp_map = '{default: srmp_pkg::MAP_RESET};
        check_map();
        #1 hard_reset_pin = 1'b0;
        repeat (4) @(posedge clk);
        acc(srmp_pkg::DIR_READ, srmp_pkg::DEV_ADDR, 5'h10, 16'h0000);
        give_verdict();
    end
endmodule : tb
